// ---- include/cjd_pkg.sv ----
// package of constants, types and decode helper for the conditional jump decoder
// Functional notes
// - opcode 001000 is control-bit relative jump
// - control-bit match loads relative target
// - offset is 5-bit two's complement
// - relative target is instruction address plus offset
// - pick 0000..1111 selects control bit 0..15
// - tested bit from executing core's control word
// - condition true when bit equals level select
// - opcode 001110 with tail 0100 is feedback far
// - feedback far match loads jump register address
// - choice bit selects one jump target register
// - picks 0..9: high-side drain/source pairs
// - picks 10..15: low-side one to six drain
// - opcode 001010 is feedback relative jump
// - feedback relative match branches by offset
package cjd_pkg;

    // instruction field positions
    localparam int OPC_HI     = 15;
    localparam int OPC_LO     = 10;
    localparam int CR_POL_BIT = 9;
    localparam int CR_PICK_HI = 8;
    localparam int CR_PICK_LO = 5;
    localparam int FB_PICK_HI = 9;
    localparam int FB_PICK_LO = 6;
    localparam int FB_POL_BIT = 5;
    localparam int JREG_BIT   = 4;
    localparam int OFF_HI     = 4;
    localparam int OFF_LO     = 0;
    localparam int TAIL_HI    = 3;
    localparam int TAIL_LO    = 0;
    localparam int OFF_W      = 5;

    // opcode values
    localparam logic [5:0] OPC_CR_REL  = 6'h08;
    localparam logic [5:0] OPC_FB_ABS  = 6'h0E;
    localparam logic [5:0] OPC_FB_REL  = 6'h0A;
    localparam logic [3:0] FB_ABS_TAIL = 4'h4;

    // register port widths and offsets
    localparam int          ADDR_W      = 10;
    localparam int          DATA_W      = 16;
    localparam int          NUM_CORES   = 4;
    localparam int          NUM_JREGS   = 2;
    localparam logic [9:0]  ADDR_CTRL_0 = 10'h101;
    localparam logic [9:0]  ADDR_CTRL_1 = 10'h102;
    localparam logic [9:0]  ADDR_CTRL_2 = 10'h121;
    localparam logic [9:0]  ADDR_CTRL_3 = 10'h122;
    localparam logic [9:0]  ADDR_JTGT_0 = 10'h140;
    localparam logic [9:0]  ADDR_JTGT_1 = 10'h141;
    localparam logic [9:0]  ADDR_STATUS = 10'h142;

    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] JTGT_RST = 16'h0000;
    localparam logic [15:0] PC_RST   = 16'h0000;

    // which of the handled jumps an instruction word is
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_CR_REL,
        KIND_FB_ABS,
        KIND_FB_REL
    } cjd_kind_t;

    // opcode decode, shared by the datapath and its checks
    function automatic cjd_kind_t cjd_decode(input logic [15:0] word);
        cjd_kind_t k;
        k = KIND_NONE;
        if (word[OPC_HI:OPC_LO] == OPC_CR_REL) begin
            k = KIND_CR_REL;
        end else if (word[OPC_HI:OPC_LO] == OPC_FB_ABS
                     && word[TAIL_HI:TAIL_LO] == FB_ABS_TAIL) begin
            k = KIND_FB_ABS;
        end else if (word[OPC_HI:OPC_LO] == OPC_FB_REL) begin
            k = KIND_FB_REL;
        end
        return k;
    endfunction

endpackage

// ---- logic/cjd_fb_select.sv ----
// feedback pick multiplexer for the pre-driver feedback signals
`timescale 1ns/1ns
module cjd_fb_select (
    input  wire logic [4:0] hs_drain_fb,   // high-side drain-source feedbacks 1..5
    input  wire logic [4:0] hs_source_fb,  // high-side source-voltage feedbacks 1..5
    input  wire logic [5:0] ls_drain_fb,   // low-side drain-source feedbacks 1..6
    input  wire logic [3:0] feedback_pick, // pick code from the instruction
    output logic            fb_bit         // selected feedback level
);
    import cjd_pkg::*;

    logic [15:0] fb_vec; // feedbacks in pick-code order

    // even codes drain, odd codes source of the same high-side driver
    for (genvar i = 0; i < 5; i++) begin : g_hs
        assign fb_vec[2*i]   = hs_drain_fb[i];
        assign fb_vec[2*i+1] = hs_source_fb[i];
    end

    // low-side drivers follow in order after the high-side pairs
    for (genvar j = 0; j < 6; j++) begin : g_ls
        assign fb_vec[10+j] = ls_drain_fb[j];
    end

    assign fb_bit = fb_vec[feedback_pick];
endmodule // cjd_fb_select

// ---- logic/cjd_rel_target.sv ----
// relative branch target adder
`timescale 1ns/1ns
module cjd_rel_target #(
    parameter int PC_W = 10
) (
    input  wire logic [PC_W-1:0] inst_addr, // address of the jump itself
    input  wire logic [4:0]      offset,    // signed relative offset
    output logic      [PC_W-1:0] target     // computed destination
);
    import cjd_pkg::*;

    // the sign extension needs a target at least as wide as the offset field
    if (PC_W < OFF_W) begin : g_bad_pc_w
        $error("PC_W must not be narrower than the offset");
    end

    logic [PC_W-1:0] off_ext; // sign-extended offset

    // sign bit is the msb of the offset field, range -16..15
    assign off_ext = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset};
    // wraps modulo code space, matching a plain address counter
    assign target  = inst_addr + off_ext;
endmodule // cjd_rel_target

// ---- logic/cjd_jump_decoder.sv ----
// conditional jump decoder: control-bit and feedback conditional branches
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module cjd_jump_decoder #(
    parameter int PC_W = 10 // code memory address width
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [cjd_pkg::ADDR_W-1:0] addr,
    input  wire logic [cjd_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [cjd_pkg::DATA_W-1:0] rdata,
    input  wire logic [1:0]                 core_id,
    input  wire logic [15:0]                instr,
    input  wire logic                       instr_valid,
    input  wire logic [4:0]                 hs_drain_fb,
    input  wire logic [4:0]                 hs_source_fb,
    input  wire logic [5:0]                 ls_drain_fb,
    output logic      [PC_W-1:0]            program_counter,
    output logic                            jump_taken,
    output logic                            cond_jump_seen
);
    import cjd_pkg::*;

    // refuse widths the relative adder and data port cannot serve
    if (PC_W < OFF_W || PC_W > DATA_W) begin : g_bad_pc_w
        $error("PC_W must lie between the offset width and the data width");
    end

    // control words and jump targets live beside the counter, so one register
    // process holds everything and a read never sees a half update
    // whole state of the block
    typedef struct packed {
        logic [NUM_CORES-1:0][15:0] ctrl;  // control words of the cores
        logic [NUM_JREGS-1:0][15:0] jtgt;  // jump target set
        logic [PC_W-1:0]            pc;    // program counter
        logic                       taken; // last instruction branched
        logic                       seen;  // last instruction was a handled jump
        cjd_kind_t                  kind;  // kind of last instruction
        logic [DATA_W-1:0]          rdata; // read answer
    } cjd_state_t;

    // decode helpers are combinational and read registered state plus instr, core_id and the feedbacks
    cjd_state_t      s_q;       // registered state
    cjd_state_t      s_d;       // next state
    logic [1:0]      rst_sync;  // reset release synchroniser
    logic            rst_int_n; // synchronised reset
    cjd_kind_t       kind;      // decode of the current word
    logic [15:0]     own_ctrl;  // control word of the executing core
    logic            ctrl_bit;  // picked control bit
    logic            fb_bit;    // picked feedback bit
    logic            cond_ok;   // condition of a handled jump holds
    logic [PC_W-1:0] rel_tgt;   // relative destination
    logic [PC_W-1:0] abs_tgt;   // absolute destination

    // reset is asserted at once but released only after two clean edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync[1];

    // condition sources and destination adder
    cjd_fb_select u_fb (
        .hs_drain_fb   (hs_drain_fb),
        .hs_source_fb  (hs_source_fb),
        .ls_drain_fb   (ls_drain_fb),
        .feedback_pick (instr[FB_PICK_HI:FB_PICK_LO]),
        .fb_bit        (fb_bit)
    );

    // the adder works from the counter as it stands, which is the address
    // of the jump being judged; the fetch has not moved on yet
    cjd_rel_target #(.PC_W(PC_W)) u_rel (
        .inst_addr (s_q.pc),
        .offset    (instr[OFF_HI:OFF_LO]),
        .target    (rel_tgt)
    );

    // decode and condition evaluation
    always_comb begin
        kind     = cjd_decode(instr);
        own_ctrl = s_q.ctrl[core_id];
        ctrl_bit = own_ctrl[instr[CR_PICK_HI:CR_PICK_LO]];
        abs_tgt  = s_q.jtgt[instr[JREG_BIT]][PC_W-1:0];
        // only the word's own kind decides which test counts; an unhandled
        // word never reports a condition
        unique case (kind)
            KIND_CR_REL: cond_ok = (ctrl_bit == instr[CR_POL_BIT]);
            KIND_FB_ABS: cond_ok = (fb_bit == instr[FB_POL_BIT]);
            KIND_FB_REL: cond_ok = (fb_bit == instr[FB_POL_BIT]);
            KIND_NONE:   cond_ok = 1'b0;
        endcase
    end

    // next-state: program counter, register writes and read answer
    always_comb begin
        s_d       = s_q;
        s_d.rdata = '0; // read data stand only in the cycle after a read
        // flags and counter move only when a word is executed, so they stand
        // until the next instruction
        if (instr_valid) begin
            s_d.kind  = kind;
            s_d.seen  = (kind != KIND_NONE);
            s_d.taken = cond_ok;
            if (cond_ok && kind == KIND_FB_ABS) begin
                s_d.pc = abs_tgt;
            end else if (cond_ok && kind == KIND_CR_REL) begin
                s_d.pc = rel_tgt;
            end else if (cond_ok && kind == KIND_FB_REL) begin
                s_d.pc = rel_tgt;
            end else begin
                // untaken or unhandled word just falls through
                s_d.pc = s_q.pc + PC_W'(1);
            end
        end
        // write side; instruction above sees the old control word
        // the status word is read-only so a stray write cannot fake a branch
        if (wr) begin
            unique case (addr)
                ADDR_CTRL_0: s_d.ctrl[0] = wdata;
                ADDR_CTRL_1: s_d.ctrl[1] = wdata;
                ADDR_CTRL_2: s_d.ctrl[2] = wdata;
                ADDR_CTRL_3: s_d.ctrl[3] = wdata;
                ADDR_JTGT_0: s_d.jtgt[0] = wdata;
                ADDR_JTGT_1: s_d.jtgt[1] = wdata;
                default:     ; // unmapped or read-only: ignored
            endcase
        end
        // read side; unmapped addresses answer zero
        if (rd) begin
            unique case (addr)
                ADDR_CTRL_0: s_d.rdata = s_q.ctrl[0];
                ADDR_CTRL_1: s_d.rdata = s_q.ctrl[1];
                ADDR_CTRL_2: s_d.rdata = s_q.ctrl[2];
                ADDR_CTRL_3: s_d.rdata = s_q.ctrl[3];
                ADDR_JTGT_0: s_d.rdata = s_q.jtgt[0];
                ADDR_JTGT_1: s_d.rdata = s_q.jtgt[1];
                ADDR_STATUS: s_d.rdata = DATA_W'({s_q.taken, s_q.seen, s_q.kind, s_q.pc});
                default:     s_d.rdata = '0;
            endcase
        end
    end

    // reset clears the control words and jump targets as well; software
    // must load them again before running code that tests them
    // state register
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_q.ctrl  <= {NUM_CORES{CTRL_RST}};
            s_q.jtgt  <= {NUM_JREGS{JTGT_RST}};
            s_q.pc    <= PC_RST[PC_W-1:0];
            s_q.taken <= 1'b0;
            s_q.seen  <= 1'b0;
            s_q.kind  <= KIND_NONE;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign rdata           = s_q.rdata;
    assign program_counter = s_q.pc;
    assign jump_taken      = s_q.taken;
    assign cond_jump_seen  = s_q.seen;

    // the checks run on the released reset, so they stay quiet while the
    // synchroniser is still holding the block
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_int_n);

    // decode, target and polarity of the control-bit word
    a_cr_decode: assert property (
        instr_valid && instr[15:10] == 6'h08 |=> cond_jump_seen && s_q.kind == KIND_CR_REL)
        else $error("control-bit jump not decoded");

    a_cr_taken_pc: assert property (
        instr_valid && kind == KIND_CR_REL && cond_ok
        |=> program_counter == $past(s_q.pc) + PC_W'($signed(($past(instr[4:0])))))
        else $error("control-bit jump target wrong");

    a_cr_polarity: assert property (
        instr_valid && kind == KIND_CR_REL
        |=> jump_taken == ($past(own_ctrl[instr[8:5]]) == $past(instr[9])))
        else $error("control-bit polarity test wrong");

    // the tested bit must come from the word of the executing core
    a_ctrl_own_core: assert property (
        instr_valid && kind == KIND_CR_REL && core_id == 2'h2
        |-> ctrl_bit == s_q.ctrl[2][instr[8:5]])
        else $error("control bit taken from wrong core");

    // far jump target and tail
    a_fb_abs_pc: assert property (
        instr_valid && kind == KIND_FB_ABS && cond_ok
        |=> program_counter == $past(s_q.jtgt[instr[4]][PC_W-1:0]))
        else $error("far feedback jump target wrong");

    a_fb_abs_tail: assert property (
        instr[15:10] == 6'h0E && instr[3:0] != 4'h4 |-> kind == KIND_NONE)
        else $error("far feedback jump decoded with bad tail");

    // feedback pick spot checks inside each group
    a_fb_low_side: assert property (
        instr[9:6] == 4'hF |-> fb_bit == ls_drain_fb[5])
        else $error("low-side six feedback not picked");

    a_fb_high_pair: assert property (
        instr[9:6] == 4'h3 |-> fb_bit == hs_source_fb[1])
        else $error("high-side two source feedback not picked");

    // most negative offset wraps backwards
    a_fb_rel_back: assert property (
        instr_valid && kind == KIND_FB_REL && cond_ok && instr[4:0] == 5'h10
        |=> program_counter == $past(s_q.pc) - PC_W'(16))
        else $error("feedback relative backward jump wrong");

    // an untaken word advances by exactly one
    a_false_adv: assert property (
        instr_valid && !cond_ok ##1 !instr_valid [*2]
        |-> program_counter == $past(s_q.pc, 2) + PC_W'(1))
        else $error("untaken jump did not advance by one");

    // decode of the two feedback words, far jump with its fixed tail
    a_fb_abs_decode: assert property (
        instr_valid && instr[15:10] == 6'h0E && instr[3:0] == 4'h4
        |=> cond_jump_seen && s_q.kind == KIND_FB_ABS)
        else $error("far feedback jump not decoded");

    a_fb_rel_decode: assert property (
        instr_valid && instr[15:10] == 6'h0A |=> cond_jump_seen && s_q.kind == KIND_FB_REL)
        else $error("feedback relative jump not decoded");

    // largest forward step must not be read as negative
    a_cr_fwd_max: assert property (
        instr_valid && kind == KIND_CR_REL && cond_ok && instr[4:0] == 5'h0F
        |=> program_counter == $past(s_q.pc) + PC_W'(15))
        else $error("largest forward offset wrong");

    // feedback relative jump: target and polarity
    a_fb_rel_pc: assert property (
        instr_valid && kind == KIND_FB_REL && cond_ok
        |=> program_counter == $past(s_q.pc) + PC_W'($signed($past(instr[4:0]))))
        else $error("feedback relative jump target wrong");

    a_fb_polarity: assert property (
        instr_valid && kind == KIND_FB_REL
        |=> jump_taken == ($past(fb_bit) == $past(instr[5])))
        else $error("feedback polarity test wrong");

    // each choice of the far jump reads its own target register
    a_jreg_zero: assert property (
        instr_valid && kind == KIND_FB_ABS && cond_ok && !instr[4]
        |=> program_counter == $past(s_q.jtgt[0][PC_W-1:0]))
        else $error("jump target register zero not used");

    a_jreg_one: assert property (
        instr_valid && kind == KIND_FB_ABS && cond_ok && instr[4]
        |=> program_counter == $past(s_q.jtgt[1][PC_W-1:0]))
        else $error("jump target register one not used");

    // both ends of the control-bit pick
    a_cr_pick_lsb: assert property (
        instr_valid && kind == KIND_CR_REL && instr[8:5] == 4'h0 |-> ctrl_bit == own_ctrl[0])
        else $error("control-bit pick zero not bit zero");

    a_cr_pick_msb: assert property (
        instr_valid && kind == KIND_CR_REL && instr[8:5] == 4'hF |-> ctrl_bit == own_ctrl[15])
        else $error("control-bit pick fifteen not bit fifteen");

    // first code of each feedback group
    a_fb_high_first: assert property (
        instr[9:6] == 4'h0 |-> fb_bit == hs_drain_fb[0])
        else $error("high-side one drain feedback not picked");

    a_fb_low_first: assert property (
        instr[9:6] == 4'hA |-> fb_bit == ls_drain_fb[0])
        else $error("low-side one drain feedback not picked");

    // untaken jumps flag themselves and the counter holds between instructions
    a_untaken_flags: assert property (
        instr_valid && kind != KIND_NONE && !cond_ok
        |=> cond_jump_seen && !jump_taken)
        else $error("untaken jump flags wrong");

    a_pc_hold: assert property (
        !instr_valid |=> $stable(program_counter))
        else $error("counter moved without an instruction");

    // read answer stands one cycle only
    a_rdata_idle: assert property (
        !$past(rd) |-> rdata == '0)
        else $error("read data outside its cycle");

    // scenarios the bench reaches, all but c_rd_after: its reads never follow a write in the next cycle
    c_cr_taken: cover property (instr_valid && kind == KIND_CR_REL && cond_ok);
    c_fb_abs:   cover property (instr_valid && kind == KIND_FB_ABS && cond_ok);
    c_fb_rel:   cover property (instr_valid && kind == KIND_FB_REL && !cond_ok);
    c_rd_after: cover property (wr ##1 rd);
    c_cr_untaken: cover property (instr_valid && kind == KIND_CR_REL && !cond_ok);
endmodule // cjd_jump_decoder

// ---- verification/cjd_core_model.sv ----
// code memory and pre-driver feedback model facing the jump decoder
`timescale 1ns/1ns
module cjd_core_model #(
    parameter int PC_W = 10 // code memory address width
) (
    input  wire logic [PC_W-1:0] program_counter,
    output logic      [15:0]     instr,
    output logic      [4:0]      hs_drain_fb,
    output logic      [4:0]      hs_source_fb,
    output logic      [5:0]      ls_drain_fb
);
    logic [15:0] mem [2**PC_W]; // code memory words

    // fetch follows the registered counter with no wait state
    assign instr = mem[program_counter];

    // blank memory reads as an unhandled word, feedbacks start low
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        hs_drain_fb  = 5'h00;
        hs_source_fb = 5'h00;
        ls_drain_fb  = 6'h00;
    end

    // place one word in code memory
    task automatic load(input logic [PC_W-1:0] a, input logic [15:0] w);
        mem[a] = w;
    endtask

    // the picked feedback gets v, all others the inverse, so a wrong pick shows
    task automatic put_fb(input int c, input logic v);
        logic [15:0] all;
        all    = {16{~v}};
        all[c] = v;
        for (int i = 0; i < 5; i++) begin
            hs_drain_fb[i]  <= all[2*i];
            hs_source_fb[i] <= all[2*i+1];
        end
        ls_drain_fb <= all[15:10];
    endtask
endmodule // cjd_core_model

// ---- verification/conditional_jump_decoder_bench.sv ----
// self-checking bench for the conditional jump decoder
`timescale 1ns/1ns
module conditional_jump_decoder_bench;
    import cjd_pkg::*;
    localparam int PW    = 10;   // code address width under test
    localparam int LIMIT = 3000; // cycle ceiling, tests need well under 1000
    logic              clk;             // core clock
    logic              rst_n;           // async reset, active low
    logic [ADDR_W-1:0] addr;            // register address
    logic [DATA_W-1:0] wdata;           // register write data
    logic              wr;              // write strobe
    logic              rd;              // read strobe
    logic [DATA_W-1:0] rdata;           // register read data
    logic [1:0]        core_id;         // executing core
    logic [15:0]       instr;           // fetched word
    logic              instr_valid;     // execute strobe
    logic [4:0]        hs_drain_fb;     // high-side drain feedbacks
    logic [4:0]        hs_source_fb;    // high-side source feedbacks
    logic [5:0]        ls_drain_fb;     // low-side drain feedbacks
    logic [PW-1:0]     program_counter; // design counter
    logic              jump_taken;      // branch flag
    logic              cond_jump_seen;  // handled-jump flag
    logic [PW-1:0]     pc_m;            // bench's own counter model
    int                mismatches;      // failed compares
    int                check_count;     // all compares
    int                cycles;          // timeout counter

    cjd_jump_decoder #(.PC_W(PW)) u_cjd_jump_decoder (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .core_id(core_id), .instr(instr), .instr_valid(instr_valid),
        .hs_drain_fb(hs_drain_fb), .hs_source_fb(hs_source_fb), .ls_drain_fb(ls_drain_fb),
        .program_counter(program_counter), .jump_taken(jump_taken),
        .cond_jump_seen(cond_jump_seen));
    cjd_core_model #(.PC_W(PW)) u_cjd_core_model (
        .program_counter(program_counter), .instr(instr), .hs_drain_fb(hs_drain_fb),
        .hs_source_fb(hs_source_fb), .ls_drain_fb(ls_drain_fb));

    // compare one value and count it
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [9:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(rdata, exp, what);
    endtask
    // relative target from the jump's own address, wrapping in code space
    function automatic logic [PW-1:0] rel(input logic [4:0] off);
        return pc_m + {{(PW-5){off[4]}}, off};
    endfunction
    // execute one word at the modelled counter and judge the outcome
    task automatic step(input logic [15:0] w, input logic tk, input logic [PW-1:0] tgt,
                        input logic sn);
        logic [PW-1:0] e;
        e = tk ? tgt : pc_m + 1'b1;
        u_cjd_core_model.load(pc_m, w);
        @(posedge clk);
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1 check(16'(program_counter), 16'(e), "pc");
        check(16'(jump_taken), 16'(tk), "taken");
        check(16'(cond_jump_seen), 16'(sn), "seen");
        pc_m = e;
    endtask

    task automatic test_reset();
        logic [9:0] ad [6] = '{ADDR_CTRL_0, ADDR_CTRL_1, ADDR_CTRL_2, ADDR_CTRL_3,
                               ADDR_JTGT_0, ADDR_JTGT_1};
        #1 check(16'(program_counter), 16'h0000, "pc reset");
        foreach (ad[i]) rd_reg(ad[i], 16'h0000, "reg reset");
        wr_reg(10'h3FF, 16'hFFFF);
        rd_reg(10'h3FF, 16'h0000, "unmapped");
        $display("test reset done");
    endtask
    task automatic test_ctrl_rel();
        logic [15:0] cw;
        logic [4:0]  off;
        cw = 16'hA5C3;
        @(posedge clk);
        core_id <= 2'd2;
        wr_reg(ADDR_CTRL_2, cw);
        rd_reg(ADDR_CTRL_2, cw, "ctrl readback");
        for (int p = 0; p < 16; p++) begin
            for (int pol = 0; pol < 2; pol++) begin
                off = p[0] ? 5'h0F : 5'h10;
                step(16'h2000 | 16'(pol << 9) | 16'(p << 5) | 16'(off),
                     cw[p] == pol[0], rel(off), 1'b1);
            end
        end
        $display("test control-bit jump done");
    endtask
    task automatic test_core_sel();
        logic [9:0] ad [4] = '{ADDR_CTRL_0, ADDR_CTRL_1, ADDR_CTRL_2, ADDR_CTRL_3};
        foreach (ad[k]) wr_reg(ad[k], 16'(1 << k));
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            core_id <= 2'(k);
            step(16'h2201 | 16'(k << 5), 1'b1, rel(5'h01), 1'b1);
            step(16'h2201 | 16'(((k + 1) % 4) << 5), 1'b0, '0, 1'b1);
        end
        $display("test core select done");
    endtask
    task automatic test_fb_rel();
        logic [4:0] off;
        for (int c = 0; c < 16; c++) begin
            for (int v = 0; v < 2; v++) begin
                off = c[1] ? 5'h10 : 5'h0E;
                @(posedge clk);
                u_cjd_core_model.put_fb(c, v[0]);
                step(16'h2800 | 16'(c << 6) | (16'(c[0]) << 5) | 16'(off),
                     v[0] == c[0], rel(off), 1'b1);
            end
        end
        $display("test feedback relative done");
    endtask
    task automatic test_fb_abs();
        wr_reg(ADDR_JTGT_0, 16'h0123);
        wr_reg(ADDR_JTGT_1, 16'h03F0);
        @(posedge clk);
        u_cjd_core_model.put_fb(12, 1'b1);
        for (int ch = 0; ch < 2; ch++) begin
            for (int pol = 0; pol < 2; pol++) begin
                step(16'h3B04 | 16'(pol << 5) | 16'(ch << 4), pol[0],
                     ch[0] ? 10'h3F0 : 10'h123, 1'b1);
            end
        end
        rd_reg(ADDR_STATUS, 16'h3800 | 16'(pc_m), "status far");
        step(16'h3A05, 1'b0, '0, 1'b0);
        wr_reg(ADDR_STATUS, 16'hFFFF);
        rd_reg(ADDR_STATUS, 16'(pc_m), "status");
        $display("test feedback far done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always #20 clk = ~clk;

    // a hung handshake ends the run as a failure
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        addr        = '0;
        wdata       = '0;
        wr          = 1'b0;
        rd          = 1'b0;
        core_id     = 2'd0;
        instr_valid = 1'b0;
        mismatches  = 0;
        check_count = 0;
        cycles      = 0;
        pc_m        = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        test_ctrl_rel();
        test_core_sel();
        test_fb_rel();
        test_fb_abs();
        test_done();
    end
endmodule // conditional_jump_decoder_bench
